/* src/sar_defines.svh */
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH
// Summary of operation
// - low gain pin maps codes onto 10%..90%
// - reset at power-up or supply below 1V
// - host waits 20us after power-on reset
// - rising start edge powers up, converts
// - start edges ignored during a conversion
// - busy high exactly while converting
// - host moves start only early or after
// - after conversion: power down and acquire
// - conversion ends within 322ns of start
// - host allows 165ns acquisition before start
// - last result kept while powered down
// - host idles output and shift clock
// - shift only when output enabled, clock runs
// - output changes on rising shift clock
// - result msb held until first rising edge
// - new msb shown when busy falls
// - host shift clock fast enough for rate
// - normal mode: read select gates output
// - host lowers one read select at once
// - read select low presents msb at once
// - chain mode: output on, pin is input
// - result is two's complement

`define SAR_CLK_NS 50
`define SAR_RESULT_W 16
`define SAR_SYNC_LAT 3
`define SAR_CONV_MAX_NS 322
`define SAR_CONV_CYCLES (`SAR_CONV_MAX_NS / `SAR_CLK_NS)
`define SAR_ACQ_MIN_NS 165
`define SAR_ACQ_CYCLES ((`SAR_ACQ_MIN_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_POR_NS 20000
`define SAR_POR_CYCLES ((`SAR_POR_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_SCK_HALF 8
// pin vector idle levels: read select idles high, every other pin low
`define SAR_PIN_IDLE 6'h04

`define SAR_REG_CTRL 8'h00
`define SAR_REG_STATUS 8'h04
`define SAR_REG_DATA 8'h08
`define SAR_CTRL_START 0
`define SAR_CTRL_CHAIN 1
`define SAR_CTRL_GAIN 2
`define SAR_CTRL_BITS_LSB 8
`define SAR_CTRL_BITS_MSB 15
`define SAR_CTRL_RESET 32'h0000_1000
`define SAR_STAT_ACTIVE 0
`define SAR_STAT_DONE 1
`define SAR_STAT_PORRDY 2
`define SAR_STAT_DEVBUSY 3
`endif

/* src/sar_pkg.sv */
package sar_pkg;
  typedef enum logic [2:0] {
    DEV_REINIT = 3'b001,
    DEV_ACQ = 3'b010,
    DEV_CONV = 3'b100
  } devState_t;
  typedef enum logic [4:0] {
    HOST_IDLE = 5'b00001,
    HOST_CNV = 5'b00010,
    HOST_WAIT = 5'b00100,
    HOST_READ = 5'b01000,
    HOST_ACQ = 5'b10000
  } hostState_t;
endpackage : sar_pkg

/* src/sar_link_if.sv */
// pins between converter and its controller; sdo is carried as data plus enable, and the host reads the data line directly
interface sar_link_if;
  logic convertStart;
  logic sck;
  logic readSelectOrChainIn;
  logic chainSel;
  logic gainCompressN;
  logic busy;
  logic sdoData;
  logic sdoEnable;
  modport device (
    input convertStart,
    input sck,
    input readSelectOrChainIn,
    input chainSel,
    input gainCompressN,
    output busy,
    output sdoData,
    output sdoEnable
  );
  modport host (
    output convertStart,
    output sck,
    output readSelectOrChainIn,
    output chainSel,
    output gainCompressN,
    input busy,
    input sdoData,
    input sdoEnable
  );
endinterface : sar_link_if

/* src/sar_adc_device.sv */
`include "sar_defines.svh"

module sar_adc_device
  import sar_pkg::*;
#(
  parameter int POR_CYCLES = `SAR_POR_CYCLES,
  parameter int CONV_CYCLES = `SAR_CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic supplyOk,
  input wire logic [`SAR_RESULT_W-1:0] analogIn,
  sar_link_if.device link
);

  localparam int W = `SAR_RESULT_W;
  // pin vector: 0 start, 1 sck, 2 read select / chain in, 3 supply, 4 chain, 5 gain
  localparam int NP = 6;
  localparam logic [15:0] CONV_LOAD = 16'(CONV_CYCLES - `SAR_SYNC_LAT);
  localparam logic [15:0] POR_LOAD = 16'(POR_CYCLES - `SAR_SYNC_LAT);

  logic [NP-1:0] pinMeta_q;
  logic [NP-1:0] pinSync_q;
  logic [NP-1:0] pinPrev_q;
  logic [W-1:0] anaMeta_q;
  logic [W-1:0] anaSync_q;
  devState_t state_q;
  logic [15:0] cnt_q;
  logic [W-1:0] sample_q;
  logic gainSample_q;
  logic [W-1:0] result_q;
  logic [W-1:0] shift_q;
  logic busy_q;
  logic sdoEn_q;
  logic cnvRise;
  logic sckRise;
  logic rdlFall;
  logic supplyGood;
  logic chainMode;
  logic convDone;

  // scale by 5/4 and clip: a compressed input span of 0.8 full scale fills the code range
  function automatic logic [W-1:0] applyGain(input logic [W-1:0] s, input logic comp);
    logic signed [W+3:0] w;
    logic [W-1:0] r;
    w = ($signed({{4{s[W-1]}}, s}) * 20'sd5) >>> 2;
    if (!comp) begin
      r = s;
    end else if (w > 20'sd32767) begin
      r = 16'h7fff;
    end else if (w < -20'sd32768) begin
      r = 16'h8000;
    end else begin
      r = w[W-1:0];
    end
    return r;
  endfunction : applyGain

  // two flops on every pin before any logic looks at it
  // reset to idle levels, else read select looks low and enables sdo right after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta_q <= `SAR_PIN_IDLE;
      pinSync_q <= `SAR_PIN_IDLE;
    end else begin
      pinMeta_q <= {link.gainCompressN, link.chainSel, supplyOk,
                    link.readSelectOrChainIn, link.sck, link.convertStart};
      pinSync_q <= pinMeta_q;
    end
  end

  // third stage only for edge detection, fed from the settled flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinPrev_q <= `SAR_PIN_IDLE;
    end else begin
      pinPrev_q <= pinSync_q;
    end
  end

  // analog sample word crosses the same way; bench holds it steady around the start edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      anaMeta_q <= '0;
      anaSync_q <= '0;
    end else begin
      anaMeta_q <= analogIn;
      anaSync_q <= anaMeta_q;
    end
  end

  assign cnvRise = pinSync_q[0] & ~pinPrev_q[0];
  assign sckRise = pinSync_q[1] & ~pinPrev_q[1];
  assign rdlFall = ~pinSync_q[2] & pinPrev_q[2];
  assign supplyGood = pinSync_q[3];
  assign chainMode = pinSync_q[4];
  assign convDone = (state_q == DEV_CONV) && (cnt_q == 16'h0001) && supplyGood;

  // power-on reset: supply loss forces reinit, which lasts just under the settle time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= DEV_REINIT;
      cnt_q <= 16'h0000;
      busy_q <= 1'b0;
    end else if (!supplyGood) begin
      state_q <= DEV_REINIT;
      cnt_q <= POR_LOAD;
      busy_q <= 1'b0;
    end else begin
      case (state_q)
        DEV_REINIT: begin
          if (cnt_q <= 16'h0001) begin
            state_q <= DEV_ACQ;
            cnt_q <= 16'h0000;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        DEV_ACQ: begin
          // powered down and tracking the input until a start edge
          if (cnvRise) begin
            state_q <= DEV_CONV;
            cnt_q <= CONV_LOAD;
            busy_q <= 1'b1;
          end
        end
        DEV_CONV: begin
          // further start edges are not looked at here
          if (cnt_q == 16'h0001) begin
            state_q <= DEV_ACQ;
            busy_q <= 1'b0;
            cnt_q <= 16'h0000;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: begin
          state_q <= DEV_REINIT;
          cnt_q <= POR_LOAD;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // the input is frozen at the start edge, gain pin taken with it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_q <= '0;
      gainSample_q <= 1'b0;
    end else if (state_q == DEV_ACQ && cnvRise && supplyGood) begin
      sample_q <= anaSync_q;
      gainSample_q <= ~pinSync_q[5];
    end
  end

  // latest result; it survives the power-down so in normal mode it can be read any time later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_q <= '0;
    end else if (convDone) begin
      result_q <= applyGain(sample_q, gainSample_q);
    end
  end

  // output shifter: reload on conversion end or, in normal mode, on read select falling; shift on rising clock while enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
    end else if (convDone) begin
      shift_q <= applyGain(sample_q, gainSample_q);
    end else if (!chainMode && rdlFall) begin
      shift_q <= result_q;
    end else if (sckRise && sdoEn_q) begin
      // chain mode pulls upstream data in behind the own bits
      shift_q <= {shift_q[W-2:0], chainMode & pinSync_q[2]};
    end
  end

  // output enable: always on in chain mode, else follows read select low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdoEn_q <= 1'b0;
    end else begin
      sdoEn_q <= chainMode | ~pinSync_q[2];
    end
  end

  // msb sits on the pin until the first rising shift edge moves it
  assign link.sdoData = shift_q[W-1];
  assign link.sdoEnable = sdoEn_q;
  assign link.busy = busy_q;

endmodule : sar_adc_device

/* src/sar_adc_host.sv */
`include "sar_defines.svh"

module sar_adc_host
  import sar_pkg::*;
#(
  parameter int POR_CYCLES = `SAR_POR_CYCLES,
  parameter int SCK_HALF = `SAR_SCK_HALF,
  parameter int ACQ_CYCLES = `SAR_ACQ_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sar_link_if.host link
);

  hostState_t state_q;
  logic [15:0] porCnt_q;
  logic porReady_q;
  logic chain_q;
  logic gainEn_q;
  logic [7:0] bitCount_q;
  logic startPend_q;
  logic done_q;
  logic [1:0] busySync_q;
  logic [1:0] sdoSync_q;
  logic [15:0] phase_q;
  logic [7:0] bitsLeft_q;
  logic [31:0] rx_q;
  logic [31:0] prdata_q;
  logic cnv_q;
  logic sck_q;
  logic rdl_q;
  logic wrEn;
  logic doneSet;

  // register map check, used only to flag unmapped offsets; the read mux is the case below
  function automatic logic mapped(input logic [7:0] a);
    return a == `SAR_REG_CTRL || a == `SAR_REG_STATUS || a == `SAR_REG_DATA;
  endfunction : mapped

  assign wrEn = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata = prdata_q;
  assign doneSet = (state_q == HOST_ACQ) && (phase_q == 16'h0000);

  // read data is captured in the setup cycle so it comes from a flop in the access cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `SAR_REG_CTRL: prdata_q <= {16'h0000, bitCount_q, 5'h00, gainEn_q, chain_q, 1'b0};
        `SAR_REG_STATUS: prdata_q <= {28'h0000000, busySync_q[1], porReady_q, done_q,
                                      state_q != HOST_IDLE};
        `SAR_REG_DATA: prdata_q <= rx_q;
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // control register and start request; a start asked for while busy is held pending
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chain_q <= 1'b0;
      gainEn_q <= 1'b0;
      bitCount_q <= 8'(`SAR_CTRL_RESET >> `SAR_CTRL_BITS_LSB);
      startPend_q <= 1'b0;
    end else begin
      if (wrEn && paddr == `SAR_REG_CTRL) begin
        chain_q <= pwdata[`SAR_CTRL_CHAIN];
        gainEn_q <= pwdata[`SAR_CTRL_GAIN];
        bitCount_q <= pwdata[`SAR_CTRL_BITS_MSB:`SAR_CTRL_BITS_LSB];
      end
      if (wrEn && paddr == `SAR_REG_CTRL && pwdata[`SAR_CTRL_START]) begin
        startPend_q <= 1'b1;
      end else if (state_q == HOST_IDLE && porReady_q) begin
        startPend_q <= 1'b0;
      end
    end
  end

  // done flag: set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (doneSet) begin
      done_q <= 1'b1;
    end else if (wrEn && paddr == `SAR_REG_STATUS && pwdata[`SAR_STAT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // no start until POR_CYCLES after reset; a later supply dip does not restart this count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      porCnt_q <= 16'h0000;
      porReady_q <= 1'b0;
    end else if (!porReady_q) begin
      porCnt_q <= porCnt_q + 16'h0001;
      porReady_q <= (porCnt_q >= 16'(POR_CYCLES - 1));
    end
  end

  // device outputs come from another domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busySync_q <= 2'b00;
      sdoSync_q <= 2'b00;
    end else begin
      busySync_q <= {busySync_q[0], link.busy};
      sdoSync_q <= {sdoSync_q[0], link.sdoData};
    end
  end

  // sequencer: start, wait for busy, shift out, then hold off for acquisition
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= HOST_IDLE;
      cnv_q <= 1'b0;
      sck_q <= 1'b0;
      rdl_q <= 1'b1;
      phase_q <= 16'h0000;
      bitsLeft_q <= 8'h00;
      rx_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        HOST_IDLE: begin
          sck_q <= 1'b0;
          rdl_q <= ~chain_q;
          if (startPend_q && porReady_q) begin
            state_q <= HOST_CNV;
            cnv_q <= 1'b1;
          end
        end
        HOST_CNV: begin
          if (busySync_q[1]) begin
            state_q <= HOST_WAIT;
          end
        end
        HOST_WAIT: begin
          // start line only falls once the conversion is over
          if (!busySync_q[1]) begin
            cnv_q <= 1'b0;
            rdl_q <= 1'b0;
            bitsLeft_q <= bitCount_q;
            phase_q <= 16'(SCK_HALF);
            state_q <= (bitCount_q == 8'h00) ? HOST_ACQ : HOST_READ;
          end
        end
        HOST_READ: begin
          if (phase_q != 16'h0000) begin
            phase_q <= phase_q - 16'h0001;
          end else if (!sck_q) begin
            // sample just before the next rising edge, long after the bit settled
            rx_q <= {rx_q[30:0], sdoSync_q[1]};
            sck_q <= 1'b1;
            bitsLeft_q <= bitsLeft_q - 8'h01;
            phase_q <= 16'(SCK_HALF);
          end else begin
            sck_q <= 1'b0;
            phase_q <= 16'(SCK_HALF);
            if (bitsLeft_q == 8'h00) begin
              rdl_q <= ~chain_q;
              phase_q <= 16'(ACQ_CYCLES);
              state_q <= HOST_ACQ;
            end
          end
        end
        HOST_ACQ: begin
          if (phase_q != 16'h0000) begin
            phase_q <= phase_q - 16'h0001;
          end else begin
            state_q <= HOST_IDLE;
          end
        end
        default: begin
          state_q <= HOST_IDLE;
          cnv_q <= 1'b0;
          sck_q <= 1'b0;
          rdl_q <= 1'b1;
        end
      endcase
    end
  end

  assign link.convertStart = cnv_q;
  assign link.sck = sck_q;
  assign link.readSelectOrChainIn = rdl_q;
  assign link.chainSel = chain_q;
  assign link.gainCompressN = ~gainEn_q;

endmodule : sar_adc_host

/* verification/sar_adc_link_chk.sv */
module sar_adc_link_chk #(
  parameter int POR_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic convertStart,
  input wire logic sck,
  input wire logic readSelectOrChainIn,
  input wire logic chainSel,
  input wire logic busy,
  input wire logic sdoData,
  input wire logic sdoEnable
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ACQ_MIN = 4;
  int upCnt;
  int idleCnt;
  // cycles since reset and since busy fell; saturate so they never wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) upCnt <= 0;
    else if (upCnt < 1000) upCnt <= upCnt + 1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) idleCnt <= 0;
    else if (busy) idleCnt <= 0;
    else if (idleCnt < 1000) idleCnt <= idleCnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_start; $rose(convertStart) && !busy |-> ##3 $rose(busy); endproperty
  a_start: assert property (p_start) else $error("start edge gave no busy");
  property p_cause; $rose(busy) |-> $past(convertStart, 3) && !$past(convertStart, 4); endproperty
  a_cause: assert property (p_cause) else $error("busy without start edge");
  property p_len; $rose(busy) |-> busy [*3] ##1 !busy; endproperty
  a_len: assert property (p_len) else $error("busy length wrong");
  property p_max; $rose(convertStart) && !busy |-> ##[1:6] $fell(busy); endproperty
  a_max: assert property (p_max) else $error("conversion too long");
  property p_hold; $fell(busy) |=> $stable(sdoData) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("msb not held");
  property p_gate; sdoEnable == ($past(chainSel, 3) || !$past(readSelectOrChainIn, 3)); endproperty
  a_gate: assert property (p_gate) else $error("output enable wrong");
  property p_shift; $changed(sdoData) |-> sdoEnable || $fell(busy); endproperty
  a_shift: assert property (p_shift) else $error("shift while disabled");
  property p_quiet; busy |-> !sck; endproperty
  a_quiet: assert property (p_quiet) else $error("shift clock during conversion");
  property p_cnv; busy |-> $stable(convertStart); endproperty
  a_cnv: assert property (p_cnv) else $error("start moved during conversion");
  property p_por; $rose(convertStart) |-> upCnt >= POR_CYCLES; endproperty
  a_por: assert property (p_por) else $error("start too soon after reset");
  property p_acq; $rose(convertStart) |-> idleCnt >= ACQ_MIN; endproperty
  a_acq: assert property (p_acq) else $error("acquisition too short");
  c_chain: cover property ($fell(busy) && chainSel);
  c_norm: cover property ($fell(busy) && !chainSel);
  c_read: cover property ($rose(sdoEnable));
endmodule : sar_adc_link_chk

/* verification/test_sar_adc_convert_serial_readout.sv */
`include "sar_defines.svh"

module test_sar_adc_convert_serial_readout;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic supplyOk = 1'b1;
  logic [15:0] analogIn = 16'h0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic [15:0] tv [6] = '{16'h8000, 16'h7fff, 16'h0000, 16'hffff, 16'h6800, 16'h8001};
  int miscompares = 0;
  int checks = 0;
  sar_link_if link ();
  sar_adc_device #(.POR_CYCLES(POR)) sar_adc_device_inst (.clk(clk), .rst(rst),
    .supplyOk(supplyOk), .analogIn(analogIn), .link(link));
  sar_adc_host #(.POR_CYCLES(POR)) sar_adc_host_inst (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  sar_adc_link_chk #(.POR_CYCLES(POR)) sar_adc_link_chk_inst (.clk(clk), .rst(rst),
    .convertStart(link.convertStart), .sck(link.sck), .chainSel(link.chainSel),
    .readSelectOrChainIn(link.readSelectOrChainIn), .busy(link.busy),
    .sdoData(link.sdoData), .sdoEnable(link.sdoEnable));
  // 20 MHz
  always #25 clk = ~clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // one apb transfer; read data and error are taken at the pready edge only
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) miscompares++;
    rd = {prdata[31:1], prdata[0] | (pslverr === 1'b1 && !wr)};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // polls a status bit; bounded so a dead design cannot hang the run
  task automatic wait_stat(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, `SAR_REG_STATUS, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 500);
    if (n >= 500) miscompares++;
  endtask : wait_stat
  // code seen at the output: plain, or scaled by 5/4 (rounded down) and clipped when compressing
  function automatic logic [15:0] exp_code(input logic [15:0] v, input logic g);
    int s;
    s = $signed(v);
    if (g) s = (s * 5) >>> 2;
    if (s > 32767) s = 32767;
    if (s < -32768) s = -32768;
    return s[15:0];
  endfunction : exp_code
  task automatic conv(input logic ch, input logic g, input logic [7:0] bits,
                      input logic [15:0] v);
    logic [31:0] cfg;
    logic [31:0] msk;
    logic [31:0] e;
    cfg = {16'h0, bits, 5'h0, g, ch, 1'b0};
    msk = (bits == 8'd32) ? 32'hffff_ffff : ((32'h1 << bits) - 32'h1);
    e = {exp_code(v, g), 16'h0} >> (32 - bits);
    analogIn <= v;
    apb(1'b1, `SAR_REG_CTRL, cfg);
    apb(1'b1, `SAR_REG_STATUS, 32'h2);
    check({30'h0, link.chainSel, link.gainCompressN}, {30'h0, ch, !g});
    apb(1'b1, `SAR_REG_CTRL, cfg | 32'h1);
    wait_stat(`SAR_STAT_DONE);
    check(rd & 32'h9, 32'h0);
    apb(1'b0, `SAR_REG_DATA, 32'h0);
    check(rd & msk, e);
    $display("conv ch=%0d g=%0d bits=%0d in=%h done", ch, g, bits, v);
  endtask : conv
  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  // watchdog well beyond the roughly 7.5k cycles the tests need
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    logic [31:0] r;
    void'($urandom(32'hab9b0e30));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // supply dip right after reset: device must reinitialise before converting
    repeat (2) @(posedge clk);
    supplyOk <= 1'b0;
    repeat (4) @(posedge clk);
    supplyOk <= 1'b1;
    apb(1'b0, `SAR_REG_CTRL, 32'h0);
    check(rd, `SAR_CTRL_RESET);
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, `SAR_REG_CTRL, 32'h0);
    check(rd, `SAR_CTRL_RESET);
    wait_stat(`SAR_STAT_PORRDY);
    repeat (POR) @(posedge clk);
    $display("reset and register test done");
    foreach (tv[i]) conv(1'b0, i[0], 8'd16, tv[i]);
    conv(1'b0, 1'b0, 8'd8, 16'ha5c3);
    conv(1'b1, 1'b0, 8'd32, 16'h1234);
    conv(1'b1, 1'b1, 8'd32, 16'hc000);
    $display("corner test done");
    repeat (8) begin
      r = $urandom();
      conv(r[16], r[17], r[16] ? 8'd32 : 8'd16, r[15:0]);
    end
    $display("random test done");
    end_of_test();
  end
endmodule : test_sar_adc_convert_serial_readout
